// *** fws_ctrl.sv ***
// Host-side polling controller for a parallel NOR flash write status.
// Assumes flash pins behind board logic; one command at a time from the user.
`timescale 1ns/1ps
module fws_ctrl
  import fws_pkg::*;
#(
  parameter int unsigned AW = 22
) (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic START,
  input wire fws_pkg::fws_method_e METHOD,
  input wire logic [AW-1:0] POLL_ADDR,
  input wire logic [7:0] EXPECT_DATA,
  input wire logic ABANDON,
  output logic BUSY,
  output logic DONE,
  output fws_pkg::fws_result_e RESULT,
  output logic [7:0] LAST_STATUS,
  output logic [AW-1:0] FL_ADDR,
  output logic FL_CE_N,
  output logic FL_OE_N,
  output logic FL_WE_N,
  output logic [7:0] FL_DQ_OUT,
  output logic FL_DQ_OE,
  input wire logic [7:0] FL_DQ_IN,
  input wire logic FL_READY_IN
);
  import fws_pkg::*;
  // Address port must fit the 32-bit flash map
  if (AW < 1 || AW > 32)
  begin : g_bad_aw
    $error("Address width out of range");
  end
  typedef enum logic [6:0] {
    S_IDLE = 7'h01, S_READ = 7'h02, S_GAP = 7'h04, S_EVAL = 7'h08,
    S_RSTW = 7'h10, S_FIN = 7'h20, S_WAIT = 7'h40
  } fws_state_e;
  fws_state_e st_q, st_d;
  logic final_q;
  logic [7:0] dq_s;
  logic ready_s;
  logic [3:0] cnt_q;
  logic [7:0] prev_q;
  logic have_prev_q;
  logic recheck_q;
  fws_method_e meth_q;
  logic [7:0] exp_q;
  logic [8:0] sync_out;
  // ==========================================================
  // Pin inputs cross two flops before use
  fws_sync #(.W(9)) u_sync (
    .clk(MCLK),
    .rst_n(RSTN),
    .d({FL_READY_IN, FL_DQ_IN}),
    .q(sync_out)
  );
  assign dq_s = sync_out[7:0];
  assign ready_s = sync_out[8];
  // ==========================================================
  // Status decode of the sampled byte
  function automatic logic toggled(input logic [7:0] a, input logic [7:0] b,
                                   input int unsigned pos);
    toggled = a[pos] ^ b[pos];
  endfunction
  wire read_done = (st_q == S_READ) && (cnt_q == 4'(READ_CYCLES - 1));
  wire pol_true = dq_s[POS_POLARITY] == exp_q[POS_POLARITY];
  wire gtog = toggled(dq_s, prev_q, POS_GTOGGLE);
  wire stog = toggled(dq_s, prev_q, POS_STOGGLE);
  wire tmo = dq_s[POS_TIMEOUT];
  wire abrt = dq_s[POS_BUFABORT];
  wire suspended = (meth_q == FWS_M_SECTOR) && !gtog && stog;
  // Completion test per method
  wire op_done = (meth_q == FWS_M_POLARITY) ? pol_true :
                 (meth_q == FWS_M_TOGGLE) ? !gtog : (!gtog && !stog);
  wire busy_pin = !ready_s;
  // ==========================================================
  // Next-state logic
  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      S_IDLE: if (START) st_d = S_READ;
      S_READ: if (read_done) st_d = final_q ? S_FIN : S_EVAL;
      S_EVAL:
      begin
        // Polarity needs no prior sample; toggle needs two reads
        if (!have_prev_q && meth_q != FWS_M_POLARITY) st_d = S_GAP;
        else if (op_done && !busy_pin) st_d = S_WAIT;
        else if (meth_q == FWS_M_POLARITY && op_done) st_d = S_WAIT;
        else if (suspended) st_d = S_FIN;
        else if (abrt && meth_q == FWS_M_POLARITY) st_d = S_RSTW;
        else if (tmo && recheck_q) st_d = S_RSTW;
        else if (ABANDON) st_d = S_FIN;
        else st_d = S_GAP;
      end
      S_GAP: if (cnt_q == 4'(GAP_CYCLES - 1)) st_d = S_READ;
      S_WAIT: if (cnt_q == 4'(GAP_CYCLES - 1)) st_d = S_READ;
      S_RSTW: if (cnt_q == 4'(WRITE_CYCLES - 1)) st_d = S_FIN;
      S_FIN: st_d = S_IDLE;
      default: st_d = S_IDLE;
    endcase
  end
  // ==========================================================
  // Cycle counter restarts on each state change
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      cnt_q <= 4'h0;
    else if (st_d != st_q)
      cnt_q <= 4'h0;
    else
      cnt_q <= cnt_q + 4'h1;
  end
  // ==========================================================
  // State, sample history and outcome
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      st_q <= S_IDLE;
      prev_q <= 8'h00;
      have_prev_q <= 1'b0;
      recheck_q <= 1'b0;
      meth_q <= FWS_M_TOGGLE;
      exp_q <= 8'h00;
      final_q <= 1'b0;
      RESULT <= FWS_R_DONE;
      LAST_STATUS <= 8'h00;
      DONE <= 1'b0;
      BUSY <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      DONE <= (st_q == S_FIN);
      BUSY <= (st_d != S_IDLE);
      if (st_q == S_IDLE && START)
      begin
        // Fresh start always forgets old samples
        meth_q <= METHOD;
        exp_q <= EXPECT_DATA;
        have_prev_q <= 1'b0;
        recheck_q <= 1'b0;
        final_q <= 1'b0;
      end
      if (st_q == S_EVAL)
      begin
        prev_q <= dq_s;
        have_prev_q <= 1'b1;
        LAST_STATUS <= dq_s;
        // Arm the recheck only once a second or later read showed no completion with timeout set
        recheck_q <= have_prev_q && tmo && !op_done;
        if (st_d == S_WAIT) final_q <= 1'b1;
        if (st_d == S_FIN) RESULT <= suspended ? FWS_R_SUSPENDED : FWS_R_ABORT;
        if (st_d == S_RSTW) RESULT <= abrt ? FWS_R_ABORT : FWS_R_FAIL;
      end
      // Array data taken from the read after completion
      if (st_q == S_READ && read_done && final_q)
      begin
        LAST_STATUS <= dq_s;
        RESULT <= FWS_R_DONE;
      end
    end
  end
  // ==========================================================
  // Pin strobes follow the next state, so they line up with S_READ and S_RSTW
  wire rd_phase = (st_d == S_READ);
  wire wr_phase = (st_d == S_RSTW);
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      FL_ADDR <= '0;
      FL_CE_N <= 1'b1;
      FL_OE_N <= 1'b1;
      FL_WE_N <= 1'b1;
      FL_DQ_OUT <= 8'h00;
      FL_DQ_OE <= 1'b0;
    end
    else
    begin
      FL_ADDR <= POLL_ADDR;
      FL_CE_N <= !(rd_phase || wr_phase);
      FL_OE_N <= !rd_phase;
      FL_WE_N <= !wr_phase;
      FL_DQ_OUT <= RESET_CMD;
      FL_DQ_OE <= wr_phase;
    end
  end
  // Completed poll ends after one confirming read
  wire fin_after_final = final_q && (st_q == S_EVAL);
  // ==========================================================
  // Assertions
  a_fail_sends_reset: assert property (@(posedge MCLK) disable iff (!RSTN)
    (st_q == S_EVAL && st_d == S_RSTW) |=> ##1 (!FL_WE_N && FL_DQ_OE))
    else $error("Reset write not issued after failure");
  a_read_strobes: assert property (@(posedge MCLK) disable iff (!RSTN)
    (st_q == S_READ) |-> (!FL_OE_N && !FL_CE_N && !FL_DQ_OE))
    else $error("Read strobes wrong during read");
  a_two_reads_first: assert property (@(posedge MCLK) disable iff (!RSTN)
    (st_q == S_EVAL && !have_prev_q && meth_q != FWS_M_POLARITY) |=> st_q == S_GAP)
    else $error("Toggle poll decided on one read");
  a_extra_read: assert property (@(posedge MCLK) disable iff (!RSTN)
    (st_q == S_EVAL && st_d == S_WAIT) |=> ##2 st_q == S_READ)
    else $error("No confirming read after completion");
  a_addr_follows: assert property (@(posedge MCLK) disable iff (!RSTN)
    (st_q != S_IDLE) |=> FL_ADDR == $past(POLL_ADDR))
    else $error("Poll address not presented");
  a_no_drive_read: assert property (@(posedge MCLK) disable iff (!RSTN)
    !(FL_DQ_OE && !FL_OE_N))
    else $error("Bus contention");
  a_restart_clean: assert property (@(posedge MCLK) disable iff (!RSTN)
    (st_q == S_IDLE && START) |=> !have_prev_q)
    else $error("Stale sample kept on restart");
  a_suspend_seen: assert property (@(posedge MCLK) disable iff (!RSTN)
    (st_q == S_EVAL && have_prev_q && suspended && !op_done && !fin_after_final)
    |=> st_q == S_FIN)
    else $error("Suspended sector not reported");
endmodule

// *** fws_pkg.sv ***
// Package for the flash write-status polling controller.
// Assumes a parallel NOR flash with status on its data bus during embedded algorithms.
package fws_pkg;
  // ==========================================================
  // Status bit positions on the data bus
  localparam int unsigned POS_POLARITY = 7;
  localparam int unsigned POS_GTOGGLE = 6;
  localparam int unsigned POS_TIMEOUT = 5;
  localparam int unsigned POS_EWINDOW = 3;
  localparam int unsigned POS_STOGGLE = 2;
  localparam int unsigned POS_BUFABORT = 1;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned READ_ACCESS_NS = 90;
  localparam int unsigned READ_CYCLES = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WRITE_PULSE_NS = 50;
  localparam int unsigned WRITE_CYCLES = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GAP_CYCLES = 2;
  // ==========================================================
  // Poll methods and outcome codes
  typedef enum logic [1:0] {FWS_M_TOGGLE = 2'h0, FWS_M_POLARITY = 2'h1,
    FWS_M_SECTOR = 2'h2} fws_method_e;
  typedef enum logic [1:0] {FWS_R_DONE = 2'h0, FWS_R_FAIL = 2'h1, FWS_R_ABORT = 2'h2,
    FWS_R_SUSPENDED = 2'h3} fws_result_e;
  // Reset command: one write of this value
  localparam logic [7:0] RESET_CMD = 8'hF0;
endpackage

// *** fws_sync.sv ***
// Two-flop synchroniser for the flash data bus and busy pin.
// Assumes inputs arrive asynchronously to MCLK.
`timescale 1ns/1ps
module fws_sync #(
  parameter int unsigned W = 17
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  // ==========================================================
  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// *** fws_flash_model.sv ***
// Behavioural flash that answers status reads for the polling bench.
// Assumes the bench arms an operation and the controller owns the pins.
`timescale 1ns/1ps
module fws_flash_model
  import fws_pkg::*;
#(
  parameter int AW = 22
) (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] din,
  input wire logic arm,
  input wire logic [2:0] mode,
  input wire logic [15:0] reads,
  input wire logic [7:0] datum,
  output logic [7:0] dq,
  output logic ready
);
  // ========================================
  // State: 0 array, 1 prog, 2 erase, 3 stuck, 4 abort, 5 suspended
  logic [2:0] md = 3'h0;
  logic tg = 1'b0;
  logic st = 1'b0;
  logic [7:0] last = 8'h00;
  int left = 0;
  wire rd = !ce_n && !oe_n;
  wire prg = md == 3'h1 || md == 3'h3 || md == 3'h4;
  wire ers = md == 3'h2;
  wire sus = md == 3'h5;
  wire [7:0] stat = (md == 3'h0) ? datum : {prg ? ~datum[7] : sus,
    tg & !sus, md == 3'h3, 1'b0, ers, st & (ers | sus), md == 3'h4, 1'b0};
  // Released bus shows the inverse, so a stale byte never passes
  assign dq = rd ? stat : ~last;
  assign ready = !(prg || ers);
  // Arm; a short count also stands for the protected-sector case
  always @(posedge arm)
  begin
    md = mode;
    left = reads;
  end
  // Each read, framed by both strobes, advances the toggles while a program, erase or suspend is shown
  always @(negedge rd)
  begin
    last = stat;
    tg = tg ^ (prg || ers);
    st = st ^ (ers || sus);
    left = left - 1;
    if ((md == 3'h1 || ers) && left <= 0) md = 3'h0;
  end
  // Reset command returns to array reads
  always @(we_n or din)
    if (!we_n && din == RESET_CMD) md = 3'h0;
endmodule

// *** fws_ctrl_bench.sv ***
// Bench for the polling controller against a behavioural flash.
// Assumes the flash model file is compiled first.
`timescale 1ns/1ps
module fws_ctrl_bench;
  import fws_pkg::*;
  logic MCLK = 1'b0;
  logic RSTN = 1'b0;
  logic START = 1'b0;
  logic ABANDON = 1'b0;
  fws_method_e METHOD = FWS_M_TOGGLE;
  logic [21:0] POLL_ADDR = 22'h00_0040;
  logic [7:0] EXPECT_DATA = 8'h00;
  logic BUSY, DONE, FL_CE_N, FL_OE_N, FL_WE_N, FL_DQ_OE, FL_READY_IN, arm = 1'b0;
  fws_result_e RESULT;
  logic [7:0] LAST_STATUS, FL_DQ_OUT, mdq, datum = 8'h00;
  logic [21:0] FL_ADDR;
  logic [2:0] mode = 3'h0;
  logic [15:0] reads = 16'h0000;
  int n_mismatch = 0;
  int n_tests = 0;
  // Shared data wire: whoever enables drives it
  wire [7:0] FL_DQ_IN = FL_DQ_OE ? FL_DQ_OUT : mdq;
  fws_ctrl #(.AW(22)) u_fws_ctrl (.MCLK, .RSTN, .START, .METHOD, .POLL_ADDR, .EXPECT_DATA,
    .ABANDON, .BUSY, .DONE, .RESULT, .LAST_STATUS, .FL_ADDR, .FL_CE_N, .FL_OE_N, .FL_WE_N,
    .FL_DQ_OUT, .FL_DQ_OE, .FL_DQ_IN, .FL_READY_IN);
  fws_flash_model #(.AW(22)) u_fws_flash_model (.ce_n(FL_CE_N), .oe_n(FL_OE_N),
    .we_n(FL_WE_N), .addr(FL_ADDR), .din(FL_DQ_IN), .arm, .mode, .reads, .datum,
    .dq(mdq), .ready(FL_READY_IN));
  initial forever #12.5 MCLK = ~MCLK;
  // ========================================
  // Compare and closing tasks
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_res(input fws_result_e got, input fws_result_e exp);
    chk_byte({6'h00, got}, {6'h00, exp});
  endtask
  task automatic wrap_up;
    $display("mismatches=%0d compares=%0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Arm the flash, then run one poll; wait is bounded
  task automatic go(input logic [2:0] m, input logic [15:0] r, input logic [7:0] d,
                    input fws_method_e k);
    int n;
    // Inputs change only by non-blocking assignment on the rising edge
    @(posedge MCLK);
    mode <= m;
    reads <= r;
    datum <= d;
    EXPECT_DATA <= d;
    METHOD <= k;
    @(posedge MCLK) arm <= 1'b1;
    @(posedge MCLK) START <= 1'b1;
    @(posedge MCLK) START <= 1'b0;
    arm <= 1'b0;
    @(negedge MCLK);
    chk_byte({7'h00, BUSY}, 8'h01);
    n = 0;
    while (DONE !== 1'b1 && n < 3000)
    begin
      @(negedge MCLK);
      n++;
    end
    if (n >= 3000) n_mismatch++;
    chk_byte({7'h00, BUSY}, 8'h00);
  endtask
  // ========================================
  // Scenarios
  task automatic t_prog_toggle;
    go(3'h1, 5, 8'h5A, FWS_M_TOGGLE);
    chk_res(RESULT, FWS_R_DONE);
    chk_byte(LAST_STATUS, 8'h5A);
  endtask
  task automatic t_prog_polar;
    go(3'h1, 4, 8'hA5, FWS_M_POLARITY);
    chk_res(RESULT, FWS_R_DONE);
    chk_byte(LAST_STATUS, 8'hA5);
  endtask
  task automatic t_erase_polar;
    go(3'h2, 4, 8'hFF, FWS_M_POLARITY);
    chk_res(RESULT, FWS_R_DONE);
  endtask
  task automatic t_suspended;
    go(3'h5, 0, 8'h00, FWS_M_SECTOR);
    chk_res(RESULT, FWS_R_SUSPENDED);
  endtask
  task automatic t_stuck;
    go(3'h3, 0, 8'h3C, FWS_M_TOGGLE);
    chk_res(RESULT, FWS_R_FAIL);
    chk_byte({5'h00, u_fws_flash_model.md}, 8'h00);
  endtask
  task automatic t_abort;
    go(3'h4, 0, 8'h81, FWS_M_POLARITY);
    chk_res(RESULT, FWS_R_ABORT);
  endtask
  task automatic t_abandon;
    @(posedge MCLK) ABANDON <= 1'b1;
    go(3'h1, 9000, 8'h11, FWS_M_TOGGLE);
    chk_res(RESULT, FWS_R_ABORT);
    @(posedge MCLK) ABANDON <= 1'b0;
  endtask
  // Main sequence after 16 cycles of reset
  initial
  begin
    repeat (16) @(posedge MCLK);
    RSTN <= 1'b1;
    t_prog_toggle();
    t_prog_polar();
    t_erase_polar();
    t_suspended();
    t_stuck();
    t_abort();
    t_abandon();
    wrap_up();
  end
  // Watchdog well past seven short polls
  initial
  begin
    repeat (20000) @(posedge MCLK);
    n_mismatch++;
    wrap_up();
  end
endmodule
